// File: hdl/dfs_map.vh
`ifndef DFS_MAP_VH
`define DFS_MAP_VH
// Clock cycles of 4 ns in the 0.1 s supervisor time base
`define DFS_TICK_CYC 25'h17D7840
// Time base ticks in one minute
`define DFS_MIN_TICKS 18'h00258
// Loss detection margin above the undervoltage level, safe margin below overvoltage level
`define DFS_LOSS_MARGIN 12'h020
`define DFS_OV_SAFE_MARGIN 12'h040
// Mains-loss stop modes
`define DFS_UVM_TRIP 2'h0
`define DFS_UVM_COAST 2'h1
`define DFS_UVM_ESTOP 2'h2
// Ramp selection codes towards the ramp control
`define DFS_RAMP_NORMAL 2'h0
`define DFS_RAMP_INERTIA 2'h1
`define DFS_RAMP_RESUME 2'h2
`define DFS_RAMP_STOP 2'h3
// Selectable status output codes
`define DFS_SEL_COAST 8'h30
`define DFS_SEL_ESTOP 8'h31
// Alarm cause bit positions
`define DFS_A_UV 0
`define DFS_A_OV 1
`define DFS_A_OC 2
`define DFS_A_DESAT 3
`define DFS_A_EXT 4
`define DFS_A_SERIAL 5
`define DFS_A_OTHER 6
// Causes that automatic reset may clear; external fault is added in external modes 2 and 3, other fault excluded
`define DFS_AR_MASK 7'h2F
`define DFS_NO_ALARM 7'h00
`endif

// File: hdl/dfs_supervisor.v
`timescale 1ns/1ns
`include "dfs_map.vh"
module dfs_supervisor #(
  parameter [24:0] P_TICK_CYC = `DFS_TICK_CYC
) (
  input wire i_mclk,
  input wire i_rst,
  input wire [11:0] i_dc_volt,
  input wire [11:0] i_uv_level,
  input wire [11:0] i_ov_level,
  input wire [1:0] i_uv_mode,
  input wire [7:0] i_pwrloss_max,
  input wire i_uv_store,
  input wire i_ovp_en,
  input wire [15:0] i_out_freq,
  input wire i_at_zero,
  input wire i_ramp_done,
  input wire i_reengage_done,
  input wire i_oc_fault,
  input wire i_desat_fault,
  input wire i_serial_timeout,
  input wire i_other_fault,
  input wire i_run,
  input wire i_reverse,
  input wire i_reset_in,
  input wire i_ext_fault_in,
  input wire [1:0] i_ext_mode,
  input wire [7:0] i_ar_attempts,
  input wire [7:0] i_ar_clear_min,
  input wire [8:0] i_ar_delay,
  input wire i_relay_policy,
  input wire [7:0] i_dout_sel,
  output reg o_bridge_en,
  output reg [1:0] o_ramp_sel,
  output reg [15:0] o_restore_freq,
  output reg o_reengage_start,
  output reg [6:0] o_alarm,
  output reg o_hist_wr,
  output reg [6:0] o_hist_cause,
  output reg o_drive_ok,
  output reg o_alarm_state,
  output reg o_no_alarm,
  output reg o_ext_fault_out,
  output reg o_coast_thru,
  output reg o_emg_stop,
  output reg o_sel_out,
  output reg o_ar_active,
  output reg [7:0] o_ar_used
);

  localparam [8:0] ST_RUN = 9'h001;
  localparam [8:0] ST_LOSS = 9'h002;
  localparam [8:0] ST_RESUME = 9'h004;
  localparam [8:0] ST_ESTOP = 9'h008;
  localparam [8:0] ST_OVP_OFF = 9'h010;
  localparam [8:0] ST_OVP_ENG = 9'h020;
  localparam [8:0] ST_OVP_STOP = 9'h040;
  localparam [8:0] ST_FAULT = 9'h080;
  localparam [8:0] ST_WAIT_RUN = 9'h100;

  // Saturating 8-bit increment for tick counters
  function [7:0] fn_inc8;
    input [7:0] v;
    begin
      fn_inc8 = (v == 8'hFF) ? v : v + 8'h01;
    end
  endfunction

  reg [3:0] s1_q;
  reg [3:0] s2_q;
  reg rst_in_q;
  reg [24:0] tick_cnt_q;
  reg under_uv_q;
  reg [7:0] dip_cnt_q;
  reg [6:0] alarm_q;
  reg [8:0] dly_q;
  reg [7:0] used_q;
  reg [17:0] clean_q;
  reg [8:0] st_q;
  reg [8:0] st_d;
  reg run_dropped_q;

  // Pin inputs pass two flip-flops: run, reverse, reset, external fault
  always @(posedge i_mclk) begin
    if (i_rst) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      rst_in_q <= 1'b0;
    end else begin
      s1_q <= {i_ext_fault_in, i_reset_in, i_reverse, i_run};
      s2_q <= s1_q;
      rst_in_q <= s2_q[2];
    end
  end

  wire run_s = s2_q[0];
  wire rev_s = s2_q[1];
  wire rst_rise = s2_q[2] & ~rst_in_q;
  wire ext_s = s2_q[3];

  // 0.1 s time base
  wire tick = (tick_cnt_q == P_TICK_CYC - 25'h0000001);
  always @(posedge i_mclk) begin
    if (i_rst || tick) begin
      tick_cnt_q <= 25'h0000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 25'h0000001;
    end
  end

  // Voltage comparisons; loss threshold sits above the undervoltage level
  wire [11:0] loss_thr = i_uv_level + `DFS_LOSS_MARGIN;
  wire mains_lost = (i_dc_volt < loss_thr);
  wire under_uv = (i_dc_volt < i_uv_level);
  wire ov_hi = (i_dc_volt >= i_ov_level);
  wire ov_safe = ({1'b0, i_dc_volt} + {1'b0, `DFS_OV_SAFE_MARGIN}) < {1'b0, i_ov_level};

  // External fault qualified by run in modes 1 and 3
  wire ext_act = ext_s & (~i_ext_mode[0] | run_s);

  // Dip timer: counts 0.1 s ticks while below undervoltage level
  always @(posedge i_mclk) begin
    if (i_rst) begin
      under_uv_q <= 1'b0;
      dip_cnt_q <= 8'h00;
    end else begin
      under_uv_q <= under_uv;
      if (!under_uv) begin
        dip_cnt_q <= 8'h00;
      end else if (tick) begin
        dip_cnt_q <= fn_inc8(dip_cnt_q);
      end
    end
  end

  // Trip only once the dip outlasts the maximum power-loss time
  wire uv_evt = under_uv & tick & (dip_cnt_q >= i_pwrloss_max);
  wire dip_start = under_uv & ~under_uv_q;
  // Overvoltage trips only with prevention off
  wire ov_evt = ov_hi & ~i_ovp_en;

  wire [6:0] ev = {i_other_fault, i_serial_timeout, ext_act, i_desat_fault,
                   i_oc_fault, ov_evt, uv_evt};
  wire [6:0] src = {i_other_fault, i_serial_timeout, ext_act, i_desat_fault,
                    i_oc_fault, ov_hi, under_uv};
  wire [6:0] ar_mask = `DFS_AR_MASK | {2'h0, i_ext_mode[1], 4'h0};
  wire any_alarm = (alarm_q != `DFS_NO_ALARM);
  wire cause_gone = ((alarm_q & src) == `DFS_NO_ALARM);

  // Auto reset allowed while all latched causes qualify and attempts remain
  wire ar_ok = any_alarm & ((alarm_q & ~ar_mask) == `DFS_NO_ALARM)
               & (used_q < i_ar_attempts);
  wire ar_fire = ar_ok & (dly_q >= i_ar_delay) & cause_gone;
  wire man_fire = rst_rise & ~run_s & ~rev_s & cause_gone;
  wire clean_done = (i_ar_clear_min != 8'h00) &&
                    (clean_q >= {10'h000, i_ar_clear_min} * `DFS_MIN_TICKS);

  // Alarm latch: a new event wins over a clear in the same cycle
  always @(posedge i_mclk) begin
    if (i_rst) begin
      alarm_q <= `DFS_NO_ALARM;
      o_hist_wr <= 1'b0;
      o_hist_cause <= `DFS_NO_ALARM;
    end else begin
      alarm_q <= ((ar_fire | man_fire) ? `DFS_NO_ALARM : alarm_q) | ev;
      o_hist_wr <= ((ev & ~alarm_q) != `DFS_NO_ALARM) | (dip_start & i_uv_store);
      o_hist_cause <= (ev & ~alarm_q) | {6'h00, dip_start & i_uv_store};
    end
  end

  // Autoreset delay, attempt counter and alarm-free clear
  always @(posedge i_mclk) begin
    if (i_rst) begin
      dly_q <= 9'h000;
      used_q <= 8'h00;
      clean_q <= 18'h00000;
    end else begin
      if (!ar_ok || ar_fire) begin
        dly_q <= 9'h000;
      end else if (tick && dly_q != 9'h1FF) begin
        dly_q <= dly_q + 9'h001;
      end
      if (man_fire || clean_done) begin
        used_q <= 8'h00;
      end else if (ar_fire) begin
        used_q <= used_q + 8'h01;
      end
      if (any_alarm || ev != `DFS_NO_ALARM || clean_done) begin
        clean_q <= 18'h00000;
      end else if (tick && clean_q != 18'h3FFFF) begin
        clean_q <= clean_q + 18'h00001;
      end
    end
  end

  // Supervisor sequence
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        if (ov_hi && i_ovp_en) begin
          st_d = ST_OVP_OFF;
        end else if (mains_lost && i_uv_mode != `DFS_UVM_TRIP && run_s) begin
          st_d = ST_LOSS;
        end
      end
      ST_LOSS: begin
        if (i_uv_mode == `DFS_UVM_ESTOP) begin
          if (i_at_zero) st_d = ST_ESTOP;
        end else if (!mains_lost) begin
          st_d = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (mains_lost) st_d = ST_LOSS;
        else if (i_ramp_done) st_d = ST_RUN;
      end
      ST_ESTOP: begin
        if (!mains_lost && run_dropped_q && run_s) st_d = ST_RUN;
      end
      ST_OVP_OFF: begin
        if (ov_safe) st_d = ST_OVP_ENG;
      end
      ST_OVP_ENG: begin
        if (i_reengage_done) st_d = ST_OVP_STOP;
      end
      ST_OVP_STOP: begin
        if (ov_hi) st_d = ST_OVP_OFF;
        else if (i_at_zero) st_d = ST_WAIT_RUN;
      end
      ST_FAULT: begin
        if (!any_alarm) st_d = ST_WAIT_RUN;
      end
      ST_WAIT_RUN: begin
        if (!run_s) st_d = ST_RUN;
      end
      default: st_d = ST_RUN;
    endcase
    // Any latched alarm overrides the sequence and keeps the bridge off
    if (any_alarm) st_d = ST_FAULT;
  end

  // State register, restart interlock and restore frequency capture
  always @(posedge i_mclk) begin
    if (i_rst) begin
      st_q <= ST_RUN;
      run_dropped_q <= 1'b0;
      o_restore_freq <= 16'h0000;
    end else begin
      st_q <= st_d;
      if (st_d != ST_ESTOP) begin
        run_dropped_q <= 1'b0;
      end else if (!run_s) begin
        run_dropped_q <= 1'b1;
      end
      if ((st_q == ST_RUN) && (st_d == ST_LOSS || st_d == ST_OVP_OFF)) begin
        o_restore_freq <= i_out_freq;
      end else if (st_q == ST_OVP_STOP && st_d == ST_OVP_OFF) begin
        o_restore_freq <= i_out_freq;
      end
    end
  end

  wire coast_d = (st_d == ST_LOSS || st_d == ST_RESUME) && (i_uv_mode == `DFS_UVM_COAST);
  wire estop_d = (st_d == ST_ESTOP) || ((st_d == ST_LOSS) && (i_uv_mode == `DFS_UVM_ESTOP));

  // Registered outputs towards power stage, ramp control and relays
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_bridge_en <= 1'b0;
      o_ramp_sel <= `DFS_RAMP_NORMAL;
      o_reengage_start <= 1'b0;
      o_alarm <= `DFS_NO_ALARM;
      o_drive_ok <= 1'b0;
      o_alarm_state <= 1'b0;
      o_no_alarm <= 1'b0;
      o_ext_fault_out <= 1'b0;
      o_coast_thru <= 1'b0;
      o_emg_stop <= 1'b0;
      o_sel_out <= 1'b0;
      o_ar_active <= 1'b0;
      o_ar_used <= 8'h00;
    end else begin
      o_bridge_en <= ~(st_d == ST_OVP_OFF || st_d == ST_FAULT);
      case (st_d)
        ST_LOSS: o_ramp_sel <= `DFS_RAMP_INERTIA;
        ST_ESTOP: o_ramp_sel <= `DFS_RAMP_INERTIA;
        ST_RESUME: o_ramp_sel <= `DFS_RAMP_RESUME;
        ST_OVP_STOP: o_ramp_sel <= `DFS_RAMP_STOP;
        default: o_ramp_sel <= `DFS_RAMP_NORMAL;
      endcase
      o_reengage_start <= (st_d == ST_OVP_ENG) && (st_q == ST_OVP_OFF);
      o_alarm <= alarm_q;
      if (ar_ok) begin
        o_drive_ok <= ~i_relay_policy;
        o_alarm_state <= i_relay_policy;
        o_no_alarm <= ~i_relay_policy;
      end else begin
        o_drive_ok <= ~any_alarm;
        o_alarm_state <= any_alarm;
        o_no_alarm <= ~any_alarm;
      end
      o_ext_fault_out <= ext_act;
      o_coast_thru <= coast_d;
      o_emg_stop <= estop_d;
      o_sel_out <= (i_dout_sel == `DFS_SEL_ESTOP) ? estop_d :
                   (i_dout_sel == `DFS_SEL_COAST) ? coast_d : 1'b0;
      o_ar_active <= ar_ok;
      o_ar_used <= used_q;
    end
  end

endmodule

// File: verif/dfs_checker.sv
`timescale 1ns/1ns
// Port-level timing checks for the fault supervisor
module dfs_checker (
  input logic i_mclk,
  input logic i_rst,
  input logic [11:0] i_dc_volt,
  input logic [11:0] i_ov_level,
  input logic i_ovp_en,
  input logic i_oc_fault,
  input logic [7:0] i_dout_sel,
  input logic [7:0] i_ar_attempts,
  input logic i_relay_policy,
  input logic o_bridge_en,
  input logic o_reengage_start,
  input logic [6:0] o_alarm,
  input logic o_hist_wr,
  input logic [6:0] o_hist_cause,
  input logic o_drive_ok,
  input logic o_alarm_state,
  input logic o_no_alarm,
  input logic o_emg_stop,
  input logic o_sel_out,
  input logic o_ar_active,
  input logic [7:0] o_ar_used
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Alarm timing, bridge and status relations
  property p_oc; i_oc_fault |-> ##2 o_alarm[2]; endproperty
  a_oc: assert property (p_oc) else $error("oc not latched");
  property p_lat; o_alarm != 7'h00 |-> !o_bridge_en; endproperty
  a_lat: assert property (p_lat) else $error("bridge on in alarm");
  property p_eng; o_reengage_start |=> !o_reengage_start; endproperty
  a_eng: assert property (p_eng) else $error("reengage not a pulse");
  property p_hist; o_hist_wr |-> o_hist_cause != 7'h00; endproperty
  a_hist: assert property (p_hist) else $error("empty history cause");
  property p_sel; i_dout_sel == 8'h31 && $past(i_dout_sel) == 8'h31 |-> o_sel_out == o_emg_stop;
  endproperty
  a_sel: assert property (p_sel) else $error("select output wrong");
  property p_ovp; i_ovp_en && o_bridge_en && i_dc_volt >= i_ov_level |-> ##[1:4] !o_bridge_en;
  endproperty
  a_ovp: assert property (p_ovp) else $error("bridge kept on");
  property p_noov; i_ovp_en && $past(i_ovp_en, 3) |-> !$rose(o_alarm[1]); endproperty
  a_noov: assert property (p_noov) else $error("overvoltage alarm stored");
  property p_zero; i_ar_attempts == 8'h00 |=> o_ar_used == 8'h00 || $stable(o_ar_used);
  endproperty
  a_zero: assert property (p_zero) else $error("attempt used at zero");
  property p_rly;
    o_ar_active && $past(o_ar_active) && $stable(i_relay_policy) |->
      o_drive_ok == !i_relay_policy && o_alarm_state == i_relay_policy &&
      o_no_alarm == !i_relay_policy;
  endproperty
  a_rly: assert property (p_rly) else $error("relay policy wrong");
  // Main scenarios reached
  c_eng: cover property (o_reengage_start);
  c_ar: cover property (o_ar_active);
  c_sel: cover property (o_sel_out);
endmodule
bind dfs_supervisor dfs_checker u_chk (.*);

// File: verif/dfs_drive_model.sv
`timescale 1ns/1ns
// Power stage, mains and ramp control facing the supervisor
module dfs_drive_model (
  input logic i_mclk,
  input logic mains_ok,
  input logic ov_push,
  input logic o_bridge_en,
  input logic [1:0] o_ramp_sel,
  input logic o_reengage_start,
  output logic [11:0] i_dc_volt,
  output logic [15:0] i_out_freq,
  output logic i_at_zero,
  output logic i_ramp_done,
  output logic i_reengage_done
);
  int spd = 0;
  int eng = 0;
  // Link sags without mains, climbs only while regenerating through the bridge
  assign i_dc_volt = !mains_ok ? 12'h210 : (ov_push && o_bridge_en) ? 12'hC80 : 12'h800;
  assign i_out_freq = 16'h1234;
  // Ramps and capture take fixed spans
  always @(posedge i_mclk) begin
    spd <= (o_ramp_sel == 2'h0) ? 0 : spd + 1;
    eng <= o_reengage_start ? 1 : (eng != 0 && eng < 6) ? eng + 1 : 0;
  end
  assign i_at_zero = o_ramp_sel[0] && spd >= 40;
  assign i_ramp_done = o_ramp_sel == 2'h2 && spd >= 20;
  assign i_reengage_done = eng == 6;
endmodule

// File: verif/dfs_supervisor_test.sv
`timescale 1ns/1ns
// Sequences of fault, reset and supply events with expected outputs
module dfs_supervisor_test;
  logic i_mclk = 0, i_rst = 1, i_uv_store = 0, i_ovp_en = 0, i_oc_fault = 0;
  logic i_desat_fault = 0, i_serial_timeout = 0, i_other_fault = 0, i_run = 0;
  logic i_reverse = 0, i_reset_in = 0, i_ext_fault_in = 0, i_relay_policy = 1;
  logic mains_ok = 1, ov_push = 0;
  logic [11:0] i_uv_level = 12'h200, i_ov_level = 12'hC00;
  logic [1:0] i_uv_mode = 2'h0, i_ext_mode = 2'h0;
  logic [7:0] i_pwrloss_max = 8'h50, i_ar_attempts = 8'h00, i_ar_clear_min = 8'h01;
  logic [7:0] i_dout_sel = 8'h30;
  logic [8:0] i_ar_delay = 9'h002;
  wire [11:0] i_dc_volt;
  wire [15:0] i_out_freq, o_restore_freq;
  wire i_at_zero, i_ramp_done, i_reengage_done, o_bridge_en, o_reengage_start, o_hist_wr;
  wire o_drive_ok, o_alarm_state, o_no_alarm, o_ext_fault_out, o_coast_thru, o_emg_stop;
  wire o_sel_out, o_ar_active;
  wire [1:0] o_ramp_sel;
  wire [6:0] o_alarm, o_hist_cause;
  wire [7:0] o_ar_used;
  int error_cnt = 0, n_compared = 0, k;
  dfs_supervisor #(.P_TICK_CYC(25'h000000A)) uut (.*);
  dfs_drive_model drive (.*);
  // Clock
  always #2 i_mclk = ~i_mclk;
  // Wait cycles, then step off the edge
  task cy(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // Compare one value
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Manual reset pulse through the pin
  task mrst;
    i_reset_in = 1;
    cy(6);
    i_reset_in = 0;
    cy(2);
  endtask
  task pulse_oc;
    i_oc_fault = 1;
    cy(1);
    i_oc_fault = 0;
  endtask
  task report_and_stop;
    $display("Compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #150000;
    error_cnt++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    cy(8);
    i_rst = 0;
    cy(3);
    chk("bridge", 1, o_bridge_en);
    i_run = 1;
    pulse_oc;
    cy(62);
    chk("alarm", 7'h04, o_alarm);
    mrst;
    chk("alarm", 7'h04, o_alarm);
    i_run = 0;
    i_reverse = 1;
    mrst;
    chk("alarm", 7'h04, o_alarm);
    i_reverse = 0;
    mrst;
    chk("alarm", 7'h00, o_alarm);
    // One automatic attempt, then exhausted
    i_ar_attempts = 8'h01;
    i_serial_timeout = 1;
    cy(1);
    i_serial_timeout = 0;
    cy(8);
    chk("alarm", 7'h20, o_alarm);
    chk("ar", 1, o_ar_active);
    chk("ok", 0, o_drive_ok);
    cy(60);
    chk("alarm", 7'h00, o_alarm);
    chk("used", 8'h01, o_ar_used);
    i_desat_fault = 1;
    cy(1);
    i_desat_fault = 0;
    cy(80);
    chk("alarm", 7'h08, o_alarm);
    mrst;
    // One more automatic reset, then the used count clears after an alarm-free minute
    i_serial_timeout = 1;
    cy(1);
    i_serial_timeout = 0;
    cy(60);
    chk("used", 8'h01, o_ar_used);
    cy(5800);
    chk("used", 8'h01, o_ar_used);
    cy(700);
    chk("used", 8'h00, o_ar_used);
    i_other_fault = 1;
    cy(1);
    i_other_fault = 0;
    cy(80);
    chk("alarm", 7'h40, o_alarm);
    mrst;
    // External fault modes with run low
    i_relay_policy = 0;
    for (k = 0; k < 4; k++) begin
      i_ext_mode = k[1:0];
      i_ext_fault_in = 1;
      cy(6);
      chk("ext", !k[0], o_ext_fault_out);
      chk("ok", k != 0, o_drive_ok);
      chk("alarm", k[0] ? 7'h00 : 7'h10, o_alarm);
      i_ext_fault_in = 0;
      cy(80);
      chk("alarm", (k[0] || k == 2) ? 7'h00 : 7'h10, o_alarm);
      mrst;
    end
    // Overvoltage prevention while running
    i_ovp_en = 1;
    i_run = 1;
    cy(6);
    ov_push = 1;
    for (k = 0; k < 50 && o_bridge_en; k++) cy(1);
    chk("bridge", 0, o_bridge_en);
    ov_push = 0;
    for (k = 0; k < 500 && !o_reengage_start; k++) cy(1);
    chk("reeng", 1, o_reengage_start);
    chk("freq", 16'h1234, o_restore_freq);
    chk("alarm", 7'h00, o_alarm);
    for (k = 0; k < 500 && o_ramp_sel != 2'h3; k++) cy(1);
    chk("ramp", 2'h3, o_ramp_sel);
    // Overvoltage again during the stop repeats the sequence
    ov_push = 1;
    for (k = 0; k < 50 && o_bridge_en; k++) cy(1);
    chk("bridge", 0, o_bridge_en);
    ov_push = 0;
    for (k = 0; k < 500 && o_ramp_sel != 2'h3; k++) cy(1);
    chk("ramp", 2'h3, o_ramp_sel);
    i_run = 0;
    cy(60);
    // Coast-through on mains loss
    i_ovp_en = 0;
    i_uv_mode = 2'h1;
    i_uv_store = 1;
    i_run = 1;
    cy(6);
    mains_ok = 0;
    cy(10);
    chk("ramp", 2'h1, o_ramp_sel);
    chk("coast", 1, o_coast_thru);
    mains_ok = 1;
    cy(6);
    chk("ramp", 2'h2, o_ramp_sel);
    i_run = 0;
    cy(40);
    // Emergency stop never resumes by itself
    i_uv_mode = 2'h2;
    i_dout_sel = 8'h31;
    i_run = 1;
    cy(6);
    mains_ok = 0;
    cy(10);
    chk("sel", 1, o_sel_out);
    mains_ok = 1;
    cy(100);
    chk("ramp", 2'h1, o_ramp_sel);
    i_run = 0;
    cy(6);
    i_run = 1;
    cy(8);
    chk("ramp", 2'h0, o_ramp_sel);
    // Trip mode: a dip longer than the power-loss time raises the undervoltage alarm
    i_uv_mode = 2'h0;
    i_uv_level = 12'h300;
    i_pwrloss_max = 8'h03;
    cy(2);
    mains_ok = 0;
    cy(20);
    chk("alarm", 7'h00, o_alarm);
    cy(30);
    chk("alarm", 7'h01, o_alarm);
    mains_ok = 1;
    cy(60);
    chk("alarm", 7'h00, o_alarm);
    chk("used", 8'h01, o_ar_used);
    report_and_stop;
  end
endmodule
